// file: verilog/smr_pkg.sv
// Purpose: Shared constants, types and decode helpers for the mode register block.
// Assumes: Device clock of 100 MHz; eight-bit register address and data.
// Notes:   Address classes drive both the read answer and the write filter.
package smr_pkg;

	// Widths
	localparam int unsigned REG_W      = 8;
	localparam int unsigned PIN_CTRL_W = 5;
	localparam int unsigned NWR_CNT_W  = 4;
	localparam int unsigned RD_CNT_W   = 3;

	typedef logic [REG_W-1:0] smr_byte_t;

	// Register addresses
	localparam smr_byte_t ADDR_DEV_INFO     = 8'h00;
	localparam smr_byte_t ADDR_BURST_CFG    = 8'h01;
	localparam smr_byte_t ADDR_LAT_SEL      = 8'h02;
	localparam smr_byte_t ADDR_DRIVE_CFG    = 8'h03;
	localparam smr_byte_t ADDR_REFRESH_STAT = 8'h04;
	localparam smr_byte_t ADDR_MAKER        = 8'h05;
	localparam smr_byte_t ADDR_REV_FIRST    = 8'h06;
	localparam smr_byte_t ADDR_REV_SECOND   = 8'h07;
	localparam smr_byte_t ADDR_ORG_INFO     = 8'h08;
	localparam smr_byte_t ADDR_TEST_MODE    = 8'h09;
	localparam smr_byte_t ADDR_IO_CAL       = 8'h0a;
	localparam smr_byte_t ADDR_BANK_MASK    = 8'h10;
	localparam smr_byte_t ADDR_SEG_MASK     = 8'h11;
	localparam smr_byte_t ADDR_PAT_FIRST    = 8'h20;
	localparam smr_byte_t ADDR_PAT_SECOND   = 8'h28;
	localparam smr_byte_t ADDR_DEV_RESET    = 8'h3f;

	// Address ranges outside the defined registers
	localparam smr_byte_t ADDR_NVM_LO      = 8'h14;
	localparam smr_byte_t ADDR_NVM_HI      = 8'h1f;
	localparam smr_byte_t ADDR_GAP_A_LO    = 8'h21;
	localparam smr_byte_t ADDR_GAP_A_HI    = 8'h27;
	localparam smr_byte_t ADDR_GAP_B_LO    = 8'h29;
	localparam smr_byte_t ADDR_GAP_B_HI    = 8'h2f;
	localparam smr_byte_t ADDR_MAKER_A_LO  = 8'h80;
	localparam smr_byte_t ADDR_MAKER_A_HI  = 8'hbe;
	localparam smr_byte_t ADDR_MAKER_B_LO  = 8'hc0;
	localparam smr_byte_t ADDR_MAKER_B_HI  = 8'hfe;
	localparam smr_byte_t ADDR_NOUSE_A     = 8'h7f;
	localparam smr_byte_t ADDR_NOUSE_B     = 8'hbf;
	localparam smr_byte_t ADDR_NOUSE_C     = 8'hff;

	// Device information and refresh status field positions
	localparam int unsigned DI_AUTO_INIT_BIT = 0;
	localparam int unsigned DI_TYPE_BIT      = 1;
	localparam int unsigned DI_INVALID_BIT   = 2;
	localparam int unsigned DI_RZQ_LSB       = 3;
	localparam int unsigned DI_RZQ_MSB       = 4;
	localparam int unsigned REFRESH_TUF_BIT  = 7;
	localparam int unsigned REFRESH_RATE_MSB = 2;

	// Write-recovery field of the burst register
	localparam int unsigned NWR_LSB          = 5;
	localparam int unsigned NWR_MSB          = 7;
	localparam logic [2:0]  NWR_CODE_MIN     = 3'h1;
	localparam logic [2:0]  NWR_CODE_MAX     = 3'h6;
	localparam logic [NWR_CNT_W-1:0] NWR_OFFSET   = 4'h2;
	localparam logic [NWR_CNT_W-1:0] NWR_RST      = 4'h3;
	localparam logic [NWR_CNT_W-1:0] PRE_FIRE_CNT = 4'h2;

	// Reset values of writable registers
	localparam smr_byte_t BURST_CFG_RST = 8'h22;
	localparam smr_byte_t CFG_RST       = 8'h00;

	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned AUTO_INIT_MAX_NS = 10000;
	localparam int unsigned AUTO_INIT_CYC    = AUTO_INIT_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned ZQ_INIT_MIN_NS   = 1000;
	localparam int unsigned ZQ_CYC           = (ZQ_INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INIT_CNT_W       = $clog2(AUTO_INIT_CYC + 1);
	localparam int unsigned ZQ_CNT_W         = $clog2(ZQ_CYC + 1);
	localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(AUTO_INIT_CYC - 1);
	localparam logic [ZQ_CNT_W-1:0]   ZQ_LAST   = ZQ_CNT_W'(ZQ_CYC - 1);

	// Read answer timing in device cycles
	localparam logic [RD_CNT_W-1:0] RD_LAT_LAST   = 3'h1;
	localparam logic [RD_CNT_W-1:0] DQS_EDGE_LAST = 3'h4;

	typedef enum logic [1:0]
	{
		RD_IDLE  = 2'h0,
		RD_LAT   = 2'h1,
		RD_BURST = 2'h3
	} smr_rd_state_t;

	typedef enum logic [2:0]
	{
		CLS_RO     = 3'h0,
		CLS_WO     = 3'h1,
		CLS_FUTURE = 3'h2,
		CLS_MAKER  = 3'h3,
		CLS_NOUSE  = 3'h4
	} smr_addr_cls_t;

	typedef struct packed
	{
		logic                  lclk_prev;
		logic                  auto_init;
		logic                  init_run;
		logic [INIT_CNT_W-1:0] init_cnt;
		logic [1:0]            rzq;
		logic                  zq_run;
		logic [ZQ_CNT_W-1:0]   zq_cnt;
		smr_byte_t             burst_cfg;
		smr_byte_t             lat_sel;
		smr_byte_t             drive_cfg;
		smr_byte_t             test_mode;
		smr_byte_t             cal_code;
		smr_byte_t             bank_mask;
		smr_byte_t             seg_mask;
		smr_rd_state_t         rd_state;
		logic [RD_CNT_W-1:0]   rd_cnt;
		smr_byte_t             rd_data;
		smr_byte_t             dq_out;
		logic                  dq_oe;
		logic                  dqs_out;
		logic                  dqs_oe;
		logic [NWR_CNT_W-1:0]  wr_rec;
		logic [NWR_CNT_W-1:0]  pre_cnt;
		logic                  pre_run;
		logic                  precharge_start;
		logic                  zq_cal_start;
		logic                  dev_reset_start;
	} smr_state_t;

	// Classify an address for both read and write handling
	function automatic smr_addr_cls_t addr_class(input smr_byte_t a);
		smr_addr_cls_t c;
		c = CLS_FUTURE;
		if (a == ADDR_DEV_INFO || a == ADDR_REFRESH_STAT || a == ADDR_MAKER || a == ADDR_REV_FIRST
			|| a == ADDR_REV_SECOND || a == ADDR_ORG_INFO || a == ADDR_PAT_FIRST || a == ADDR_PAT_SECOND)
			c = CLS_RO;
		else if (a == ADDR_BURST_CFG || a == ADDR_LAT_SEL || a == ADDR_DRIVE_CFG || a == ADDR_TEST_MODE
			|| a == ADDR_IO_CAL || a == ADDR_BANK_MASK || a == ADDR_SEG_MASK || a == ADDR_DEV_RESET)
			c = CLS_WO;
		else if ((a >= ADDR_MAKER_A_LO && a <= ADDR_MAKER_A_HI) || (a >= ADDR_MAKER_B_LO && a <= ADDR_MAKER_B_HI))
			c = CLS_MAKER;
		else if (a == ADDR_NOUSE_A || a == ADDR_NOUSE_B || a == ADDR_NOUSE_C
			|| (a >= ADDR_NVM_LO && a <= ADDR_NVM_HI)
			|| (a >= ADDR_GAP_A_LO && a <= ADDR_GAP_A_HI) || (a >= ADDR_GAP_B_LO && a <= ADDR_GAP_B_HI))
			c = CLS_NOUSE;
		return c;
	endfunction : addr_class

	// Write-recovery code to cycle count; reserved codes keep the old count
	function automatic logic [NWR_CNT_W-1:0] nwr_decode(input logic [2:0] code, input logic [NWR_CNT_W-1:0] old);
		logic [NWR_CNT_W-1:0] n;
		n = old;
		if (code >= NWR_CODE_MIN && code <= NWR_CODE_MAX)
			n = NWR_CNT_W'({1'b0, code}) + NWR_OFFSET;
		return n;
	endfunction : nwr_decode

endpackage : smr_pkg

// file: verilog/smr_sync.sv
// Purpose: Two-stage synchroniser for pins from outside the device clock.
// Assumes: Each bit is a level; multi-bit groups are held stable by the sender.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
module smr_sync
#(
	parameter int unsigned W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed
	{
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} smr_sync_st_t;

	smr_sync_st_t st;
	smr_sync_st_t next_st;

	// Shift through two flops
	always_comb
	begin
		next_st.meta = d;
		next_st.sync = st.meta;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.sync;

endmodule : smr_sync

// file: verilog/smr_mode_regs.sv
// Purpose: Mode register file reached by read and write commands on the command pins.
// Assumes: Command pins and link clock are asynchronous and held across a link clock rising edge.
// Notes:   Reads answer with a four-edge strobe burst; data of unreadable addresses is zero.
`timescale 1ns/1ps

// Summary of operation
// - Data and strobe outputs stay high impedance while clock enable is sampled low.
// - Read command returns the addressed register contents.
// - Write command updates the addressed register from the operand byte.
// - Future-reserved bits read back as zero.
// - Reads of write-only or reserved registers still toggle the strobe normally.
// - Writes to read-only registers are ignored without side effects.
// - Calibration write starts calibration; reset write starts device reset; neither readable.
// - Addresses 0x20 and 0x28 return the first and second calibration patterns.
// - Bit 0 of device information shows auto-init in progress; it clears only after an init started by a reset write, not after rst_n.
// - Write-recovery field sets cycles from auto-precharge write end to precharge.
module smr_mode_regs
#(
	parameter logic             DEVICE_TYPE_FLAG  = 1'b0,
	parameter logic             DATA_INVALID_FLAG = 1'b0,
	parameter logic [1:0]       RZQ_RESULT        = 2'h3,
	parameter smr_pkg::smr_byte_t MAKER_ID        = 8'h5a, // Arbitrary value
	parameter smr_pkg::smr_byte_t REV_FIRST_ID    = 8'h01, // Arbitrary value
	parameter smr_pkg::smr_byte_t REV_SECOND_ID   = 8'h02, // Arbitrary value
	parameter smr_pkg::smr_byte_t ORG_INFO        = 8'h00,
	parameter smr_pkg::smr_byte_t PATTERN_FIRST   = 8'h55,
	parameter smr_pkg::smr_byte_t PATTERN_SECOND  = 8'h33
)
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                link_clk,
	input  wire logic                cke,
	input  wire logic                cs_n,
	input  wire logic                mode_reg_read_cmd,
	input  wire logic                mode_reg_write_cmd,
	input  wire smr_pkg::smr_byte_t  cmd_addr,
	input  wire smr_pkg::smr_byte_t  cmd_data,
	input  wire logic                wr_burst_ap_end,
	input  wire logic                temp_update_flag,
	input  wire logic [2:0]          refresh_rate,
	output smr_pkg::smr_byte_t       dq_out,
	output logic                     dq_oe,
	output logic                     dqs_out,
	output logic                     dqs_oe,
	output logic                     auto_init_status,
	output logic [3:0]               write_recovery_cycles,
	output logic                     precharge_start,
	output logic                     zq_cal_start,
	output smr_pkg::smr_byte_t       zq_cal_code,
	output logic                     dev_reset_start,
	output smr_pkg::smr_byte_t       burst_feature_config,
	output smr_pkg::smr_byte_t       latency_select,
	output smr_pkg::smr_byte_t       output_drive_config,
	output smr_pkg::smr_byte_t       test_mode_code,
	output smr_pkg::smr_byte_t       bank_refresh_mask,
	output smr_pkg::smr_byte_t       segment_refresh_mask
);

	localparam int unsigned SYNC_W = smr_pkg::PIN_CTRL_W + 2 * smr_pkg::REG_W;

	localparam smr_pkg::smr_state_t RST_ST = '{
		auto_init: 1'b1,
		burst_cfg: smr_pkg::BURST_CFG_RST,
		lat_sel:   smr_pkg::CFG_RST,
		drive_cfg: smr_pkg::CFG_RST,
		test_mode: smr_pkg::CFG_RST,
		cal_code:  smr_pkg::CFG_RST,
		bank_mask: smr_pkg::CFG_RST,
		seg_mask:  smr_pkg::CFG_RST,
		rd_state:  smr_pkg::RD_IDLE,
		wr_rec:    smr_pkg::NWR_RST,
		default:   '0
	};

	smr_pkg::smr_state_t  st;
	smr_pkg::smr_state_t  next_st;
	logic [SYNC_W-1:0]    pins_s;
	logic                 s_lclk;
	logic                 s_cke;
	logic                 s_cs_n;
	logic                 s_rd;
	logic                 s_wr;
	smr_pkg::smr_byte_t   s_addr;
	smr_pkg::smr_byte_t   s_data;

	// Every command pin and the link clock cross two flops before any decode
	smr_sync
	#(
		.W (SYNC_W)
	)
	u_pin_sync
	(
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({link_clk, cke, cs_n, mode_reg_read_cmd, mode_reg_write_cmd, cmd_addr, cmd_data}),
		.q     (pins_s)
	);

	assign {s_lclk, s_cke, s_cs_n, s_rd, s_wr, s_addr, s_data} = pins_s;

	// Next-state logic for the whole block
	always_comb
	begin
		logic                   cmd_take;
		smr_pkg::smr_addr_cls_t cls;
		smr_pkg::smr_byte_t     rd_val;
		smr_pkg::smr_byte_t     info;
		smr_pkg::smr_byte_t     refr;
		cmd_take = 1'b0;
		cls      = smr_pkg::CLS_FUTURE;
		rd_val   = '0;
		info     = '0;
		refr     = '0;

		next_st                 = st;
		next_st.lclk_prev       = s_lclk;
		next_st.precharge_start = 1'b0;
		next_st.zq_cal_start    = 1'b0;
		next_st.dev_reset_start = 1'b0;

		// Commands are taken on a link clock rising edge with the device selected
		cmd_take = s_lclk & ~st.lclk_prev & s_cke & ~s_cs_n;
		cls = smr_pkg::addr_class(s_addr);

		if (st.init_run)
		begin
			if (st.init_cnt == smr_pkg::INIT_LAST)
			begin
				next_st.auto_init = 1'b0;
				next_st.init_run  = 1'b0;
			end
			else
				next_st.init_cnt = st.init_cnt + 1'b1;
		end

		// Calibration result posts after the minimum calibration time
		if (st.zq_run)
		begin
			if (st.zq_cnt == smr_pkg::ZQ_LAST)
			begin
				next_st.rzq    = RZQ_RESULT;
				next_st.zq_run = 1'b0;
			end
			else
				next_st.zq_cnt = st.zq_cnt + 1'b1;
		end

		if (wr_burst_ap_end)
		begin
			next_st.pre_run = 1'b1;
			next_st.pre_cnt = st.wr_rec;
		end
		else if (st.pre_run)
		begin
			if (st.pre_cnt == smr_pkg::PRE_FIRE_CNT)
			begin
				next_st.precharge_start = 1'b1;
				next_st.pre_run         = 1'b0;
			end
			else
				next_st.pre_cnt = st.pre_cnt - 1'b1;
		end

		info[smr_pkg::DI_AUTO_INIT_BIT]                  = st.auto_init;
		info[smr_pkg::DI_TYPE_BIT]                       = DEVICE_TYPE_FLAG;
		info[smr_pkg::DI_INVALID_BIT]                    = DATA_INVALID_FLAG;
		info[smr_pkg::DI_RZQ_MSB:smr_pkg::DI_RZQ_LSB]    = st.rzq;
		refr[smr_pkg::REFRESH_TUF_BIT]                   = temp_update_flag;
		refr[smr_pkg::REFRESH_RATE_MSB:0]                = refresh_rate;

		unique case (s_addr)
			smr_pkg::ADDR_DEV_INFO:     rd_val = info;
			smr_pkg::ADDR_REFRESH_STAT: rd_val = refr;
			smr_pkg::ADDR_MAKER:        rd_val = MAKER_ID;
			smr_pkg::ADDR_REV_FIRST:    rd_val = REV_FIRST_ID;
			smr_pkg::ADDR_REV_SECOND:   rd_val = REV_SECOND_ID;
			smr_pkg::ADDR_ORG_INFO:     rd_val = ORG_INFO;
			smr_pkg::ADDR_PAT_FIRST:    rd_val = PATTERN_FIRST;
			smr_pkg::ADDR_PAT_SECOND:   rd_val = PATTERN_SECOND;
			default:                    rd_val = '0;
		endcase
		if (cls != smr_pkg::CLS_RO)
			rd_val = '0;

		unique case (st.rd_state)
			smr_pkg::RD_IDLE:
			begin
				next_st.dq_oe  = 1'b0;
				next_st.dqs_oe = 1'b0;
				// every address gets a strobe burst
				if (cmd_take && s_rd && !s_wr)
				begin
					// Strobe preamble starts one cycle after the take
					next_st.dqs_oe   = 1'b1;
					next_st.dqs_out  = 1'b0;
					next_st.rd_data  = rd_val;
					next_st.rd_cnt   = smr_pkg::RD_LAT_LAST;
					next_st.rd_state = smr_pkg::RD_LAT;
				end
			end
			smr_pkg::RD_LAT:
			begin
				// Strobe driven low as preamble
				next_st.dqs_oe  = 1'b1;
				next_st.dqs_out = 1'b0;
				if (st.rd_cnt == '0)
				begin
					next_st.dq_oe    = 1'b1;
					next_st.dq_out   = st.rd_data;
					next_st.rd_cnt   = smr_pkg::DQS_EDGE_LAST;
					next_st.rd_state = smr_pkg::RD_BURST;
				end
				else
					next_st.rd_cnt = st.rd_cnt - 1'b1;
			end
			smr_pkg::RD_BURST:
			begin
				next_st.dqs_out = ~st.dqs_out;
				if (st.rd_cnt == '0)
				begin
					next_st.dq_oe    = 1'b0;
					next_st.dqs_oe   = 1'b0;
					next_st.dqs_out  = 1'b0;
					next_st.rd_state = smr_pkg::RD_IDLE;
				end
				else
					next_st.rd_cnt = st.rd_cnt - 1'b1;
			end
			default:
			begin
				next_st.dq_oe    = 1'b0;
				next_st.dqs_oe   = 1'b0;
				next_st.rd_state = smr_pkg::RD_IDLE;
			end
		endcase

		// write stores operand; read-only and reserved ignored
		if (cmd_take && s_wr && !s_rd && cls == smr_pkg::CLS_WO)
		begin
			unique case (s_addr)
				smr_pkg::ADDR_BURST_CFG:
				begin
					next_st.burst_cfg = s_data;
					next_st.wr_rec    = smr_pkg::nwr_decode(s_data[smr_pkg::NWR_MSB:smr_pkg::NWR_LSB], st.wr_rec);
				end
				smr_pkg::ADDR_LAT_SEL:   next_st.lat_sel   = s_data;
				smr_pkg::ADDR_DRIVE_CFG: next_st.drive_cfg = s_data;
				smr_pkg::ADDR_TEST_MODE: next_st.test_mode = s_data;
				smr_pkg::ADDR_BANK_MASK: next_st.bank_mask = s_data;
				smr_pkg::ADDR_SEG_MASK:  next_st.seg_mask  = s_data;
				smr_pkg::ADDR_IO_CAL:
				begin
					next_st.cal_code     = s_data;
					next_st.zq_cal_start = 1'b1;
					next_st.zq_run       = 1'b1;
					next_st.zq_cnt       = '0;
				end
				smr_pkg::ADDR_DEV_RESET:
				begin
					next_st                 = RST_ST;
					next_st.lclk_prev       = s_lclk;
					next_st.init_run        = 1'b1;
					next_st.dev_reset_start = 1'b1;
				end
				default: next_st.test_mode = st.test_mode;
			endcase
		end

		// no drive while clock enable low
		if (!s_cke)
		begin
			next_st.dq_oe    = 1'b0;
			next_st.dqs_oe   = 1'b0;
			next_st.dqs_out  = 1'b0;
			next_st.rd_state = smr_pkg::RD_IDLE;
		end
	end

	// Single state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= RST_ST;
		else
			st <= next_st;
	end

	// Outputs come straight from the state flops
	assign dq_out                = st.dq_out;
	assign dq_oe                 = st.dq_oe;
	assign dqs_out               = st.dqs_out;
	assign dqs_oe                = st.dqs_oe;
	assign auto_init_status      = st.auto_init;
	assign write_recovery_cycles = st.wr_rec;
	assign precharge_start       = st.precharge_start;
	assign zq_cal_start          = st.zq_cal_start;
	assign zq_cal_code           = st.cal_code;
	assign dev_reset_start       = st.dev_reset_start;
	assign burst_feature_config  = st.burst_cfg;
	assign latency_select        = st.lat_sel;
	assign output_drive_config   = st.drive_cfg;
	assign test_mode_code        = st.test_mode;
	assign bank_refresh_mask     = st.bank_mask;
	assign segment_refresh_mask  = st.seg_mask;

endmodule : smr_mode_regs

// file: tb/smr_mode_regs_monitor.sv
// Purpose: Port checks for the mode register block.
// Assumes: One clock domain, rst_n async active low.
// Notes:   Precharge and auto-init spans use helper counters.
`timescale 1ns/1ps
module smr_mode_regs_monitor
(
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               cke,
	input wire logic               wr_burst_ap_end,
	input wire smr_pkg::smr_byte_t dq_out,
	input wire logic               dq_oe,
	input wire logic               dqs_out,
	input wire logic               dqs_oe,
	input wire logic               auto_init_status,
	input wire logic [3:0]         write_recovery_cycles,
	input wire logic               precharge_start,
	input wire logic               zq_cal_start,
	input wire logic               dev_reset_start,
	input wire smr_pkg::smr_byte_t burst_feature_config
);
	typedef struct packed {logic [3:0] pre; logic [10:0] init;} smr_mon_t;
	smr_mon_t st;
	smr_mon_t next_st;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycle counts since end pulse and reset command; saturate to avoid wrap
	always_comb
	begin
		next_st = st;
		if (wr_burst_ap_end) next_st.pre = 4'h1;
		else if (st.pre != 4'h0 && st.pre != 4'hf) next_st.pre = st.pre + 4'h1;
		if (dev_reset_start) next_st.init = 11'h001;
		else if (st.init != 11'h000 && st.init != 11'h7ff) next_st.init = st.init + 11'h001;
	end
	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n) st <= '0;
		else st <= next_st;
	end
	sequence preamble_s; (!dqs_out && !dq_oe) ##1 (dqs_oe && !dqs_out && !dq_oe) ##1 (dq_oe && !dqs_out); endsequence
	sequence toggles_s; dqs_out ##1 !dqs_out ##1 dqs_out ##1 !dqs_out; endsequence
	read_burst_a: assert property ($rose(dqs_oe) |-> preamble_s ##1 toggles_s ##1 (!dqs_oe && !dq_oe))
		else $error("read strobe burst malformed");
	dq_hold_a: assert property ((dq_oe && $past(dq_oe)) |-> $stable(dq_out))
		else $error("read data moved during burst");
	cke_hiz_a: assert property (!cke [*5] |-> (!dq_oe && !dqs_oe))
		else $error("outputs driven with clock enable low");
	oe_pair_a: assert property (dq_oe |-> dqs_oe)
		else $error("data driven without strobe");
	nwr_range_a: assert property (write_recovery_cycles >= 4'h3 && write_recovery_cycles <= 4'h8)
		else $error("write recovery count out of range");
	precharge_a: assert property (precharge_start |-> st.pre == write_recovery_cycles)
		else $error("precharge at wrong cycle");
	zq_pulse_a: assert property (zq_cal_start |=> !zq_cal_start)
		else $error("calibration start not a pulse");
	reset_cmd_a: assert property (dev_reset_start |=> (auto_init_status && burst_feature_config == 8'h22))
		else $error("reset command did not reinitialise");
	init_hold_a: assert property (dev_reset_start |=> auto_init_status [*8])
		else $error("auto init status dropped early");
	init_fall_a: assert property ($fell(auto_init_status) |-> (st.init >= 11'h3e3 && st.init <= 11'h3ed))
		else $error("auto init finished at wrong time");
endmodule : smr_mode_regs_monitor
bind smr_mode_regs smr_mode_regs_monitor smr_mode_regs_monitor_inst (.clk(clk), .rst_n(rst_n), .cke(cke),
	.wr_burst_ap_end(wr_burst_ap_end), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
	.auto_init_status(auto_init_status), .write_recovery_cycles(write_recovery_cycles),
	.precharge_start(precharge_start), .zq_cal_start(zq_cal_start), .dev_reset_start(dev_reset_start),
	.burst_feature_config(burst_feature_config));

// file: tb/smr_ctrl_model.sv
// Purpose: Memory controller model issuing mode register commands.
// Assumes: Pins change on the falling device clock edge.
// Notes:   Link clock runs only inside a command frame.
`timescale 1ns/1ps
module smr_ctrl_model
(
	input  wire logic         clk,
	output logic              link_clk,
	output logic              cke,
	output logic              cs_n,
	output logic              mode_reg_read_cmd,
	output logic              mode_reg_write_cmd,
	output smr_pkg::smr_byte_t cmd_addr,
	output smr_pkg::smr_byte_t cmd_data
);
	logic slow;
	// Idle pins at time zero
	initial
	begin
		{link_clk, mode_reg_read_cmd, mode_reg_write_cmd, slow} = 4'h0;
		{cke, cs_n} = 2'h3;
		cmd_addr = 8'h00;
		cmd_data = 8'h00;
	end
	task automatic set_cke(input logic v);
		@(negedge clk);
		cke = v;
	endtask : set_cke
	// One command frame; released address and data pins show inverted values, not the last ones
	task automatic issue(input logic is_wr, input smr_pkg::smr_byte_t a, input smr_pkg::smr_byte_t d);
		smr_pkg::smr_byte_t dd;
		dd = d;
		if (is_wr && (a inside {[8'h0b:8'h0f], [8'h12:8'h13], [8'h30:8'h3e], [8'h40:8'h7e]})) return;
		if (is_wr && (a == smr_pkg::ADDR_LAT_SEL || a == smr_pkg::ADDR_DRIVE_CFG)) dd = d & 8'h0f;
		repeat (slow ? 6 : 1) @(negedge clk);
		{cs_n, mode_reg_read_cmd, mode_reg_write_cmd} = {1'b0, !is_wr, is_wr};
		{cmd_addr, cmd_data} = {a, dd};
		repeat (4) @(negedge clk);
		link_clk = 1'b1;
		repeat (4) @(negedge clk);
		link_clk = 1'b0;
		{cs_n, mode_reg_read_cmd, mode_reg_write_cmd} = 3'h4;
		{cmd_addr, cmd_data} = {~a, ~dd};
	endtask : issue
endmodule : smr_ctrl_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the mode register block.
// Assumes: 100 MHz clock, link clock one 40 ns high pulse per command frame.
// Notes:   Reads queue their expected byte; a watcher compares.
`timescale 1ns/1ps
module tb_top;
	logic clk, rst_n, link_clk, cke, cs_n, rd_cmd, wr_cmd_pin, wr_burst_ap_end, temp_update_flag;
	logic dq_oe, dqs_out, dqs_oe, auto_init_status, precharge_start, zq_cal_start, dev_reset_start;
	logic [2:0] refresh_rate;
	logic [3:0] write_recovery_cycles;
	smr_pkg::smr_byte_t cmd_addr, cmd_data, dq_out, zq_cal_code, burst_feature_config, latency_select;
	smr_pkg::smr_byte_t output_drive_config, test_mode_code, bank_refresh_mask, segment_refresh_mask;
	smr_pkg::smr_byte_t exp_q[$], ro_a[8], ro_e[8], nr_a[9], wo_a[6], bad_a[6], d;
	logic [63:0] s;
	int mismatches, tests_run, n;
	logic [3:0] nwr_exp;
	smr_mode_regs smr_mode_regs_inst (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cke(cke), .cs_n(cs_n),
		.mode_reg_read_cmd(rd_cmd), .mode_reg_write_cmd(wr_cmd_pin), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.wr_burst_ap_end(wr_burst_ap_end), .temp_update_flag(temp_update_flag), .refresh_rate(refresh_rate),
		.dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .auto_init_status(auto_init_status),
		.write_recovery_cycles(write_recovery_cycles), .precharge_start(precharge_start),
		.zq_cal_start(zq_cal_start), .zq_cal_code(zq_cal_code), .dev_reset_start(dev_reset_start),
		.burst_feature_config(burst_feature_config), .latency_select(latency_select),
		.output_drive_config(output_drive_config), .test_mode_code(test_mode_code),
		.bank_refresh_mask(bank_refresh_mask), .segment_refresh_mask(segment_refresh_mask));
	smr_ctrl_model smr_ctrl_model_inst (.clk(clk), .link_clk(link_clk), .cke(cke), .cs_n(cs_n),
		.mode_reg_read_cmd(rd_cmd), .mode_reg_write_cmd(wr_cmd_pin), .cmd_addr(cmd_addr), .cmd_data(cmd_data));
	// Device clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict;
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	always @(posedge dq_oe)
	begin
		#1;
		if (exp_q.size() != 0) chk(dq_out, exp_q.pop_front());
		else chk(64'h1, 64'h0);
	end
	// Read with a queued expectation; bounded wait, then the burst tail
	task automatic rd_exp(input smr_pkg::smr_byte_t a, input smr_pkg::smr_byte_t e);
		exp_q.push_back(e);
		smr_ctrl_model_inst.issue(1'b0, a, 8'h00);
		for (n = 0; n < 40 && exp_q.size() != 0; n++) @(negedge clk);
		repeat (8) @(negedge clk);
	endtask : rd_exp
	task automatic wr_reg(input smr_pkg::smr_byte_t a, input smr_pkg::smr_byte_t v);
		smr_ctrl_model_inst.issue(1'b1, a, v);
		repeat (4) @(negedge clk);
	endtask : wr_reg
	function automatic logic [63:0] snap();
		return {burst_feature_config, latency_select, output_drive_config, test_mode_code, bank_refresh_mask,
			segment_refresh_mask, zq_cal_code, 4'h0, write_recovery_cycles};
	endfunction : snap
	function automatic smr_pkg::smr_byte_t cfg_of(input smr_pkg::smr_byte_t a);
		s = snap();
		return (a == 8'h01) ? s[63:56] : (a == 8'h02) ? s[55:48] : (a == 8'h03) ? s[47:40] :
			(a == 8'h09) ? s[39:32] : (a == 8'h10) ? s[31:24] : s[23:16];
	endfunction : cfg_of
	// Hang guard
	initial
	begin
		#200000;
		mismatches++;
		give_verdict();
	end
	// Main sequence
	initial
	begin
		{rst_n, wr_burst_ap_end, temp_update_flag, refresh_rate, mismatches, tests_run} = '0;
		void'($urandom(32'hd612394e));
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk(snap(), {8'h22, 48'h0, 8'h03});
		chk(auto_init_status, 1'b1);
		temp_update_flag = 1'($urandom);
		refresh_rate = 3'($urandom);
		ro_a = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
		ro_e = '{8'h01, {temp_update_flag, 4'h0, refresh_rate}, 8'h5a, 8'h01, 8'h02, 8'h00, 8'h55, 8'h33};
		foreach (ro_a[i]) rd_exp(ro_a[i], ro_e[i]);
		nr_a = '{8'h01, 8'h09, 8'h0a, 8'h0b, 8'h3f, 8'h80, 8'hff, 8'h7f, 8'h21};
		smr_ctrl_model_inst.slow = 1'b1;
		foreach (nr_a[i]) rd_exp(nr_a[i], 8'h00);
		smr_ctrl_model_inst.slow = 1'b0;
		wo_a = '{8'h02, 8'h03, 8'h09, 8'h10, 8'h11, 8'h01};
		foreach (wo_a[i])
		begin
			d = 8'($urandom);
			if (wo_a[i] == 8'h01) d[7:5] = 3'(1 + $urandom_range(5));
			if (wo_a[i] < 8'h04) d = (wo_a[i] == 8'h01) ? d : d & 8'h0f;
			wr_reg(wo_a[i], d);
			chk(cfg_of(wo_a[i]), d);
		end
		nwr_exp = {1'b0, d[7:5]} + 4'h2;
		chk(write_recovery_cycles, nwr_exp);
		s = snap();
		bad_a = '{8'h00, 8'h05, 8'h20, 8'h28, 8'h80, 8'hbf};
		foreach (bad_a[i]) wr_reg(bad_a[i], 8'($urandom));
		chk(snap(), s);
		wr_burst_ap_end = 1'b1;
		@(posedge clk);
		@(negedge clk);
		wr_burst_ap_end = 1'b0;
		for (n = 1; n < 20 && precharge_start !== 1'b1; n++) @(negedge clk);
		chk(n, nwr_exp);
		d = 8'($urandom);
		wr_reg(8'h0a, d);
		chk(zq_cal_code, d);
		repeat (110) @(negedge clk);
		rd_exp(8'h00, 8'h19);
		// no drive with clock enable low
		smr_ctrl_model_inst.set_cke(1'b0);
		repeat (5) @(negedge clk);
		smr_ctrl_model_inst.issue(1'b0, 8'h05, 8'h00);
		s = 64'h0;
		repeat (16) @(negedge clk) s[0] = s[0] | dqs_oe | dq_oe;
		chk(s, 64'h0);
		smr_ctrl_model_inst.set_cke(1'b1);
		repeat (4) @(negedge clk);
		wr_reg(8'h3f, 8'h00);
		s = snap();
		chk({s[63:16], s[7:0]}, {8'h22, 40'h0, 8'h03});
		chk(auto_init_status, 1'b1);
		for (n = 0; n < 1200 && auto_init_status === 1'b1; n++) @(negedge clk);
		chk(auto_init_status, 1'b0);
		rd_exp(8'h00, 8'h00);
		chk(exp_q.size(), 0);
		give_verdict();
	end
endmodule : tb_top
